/* File: hdl/supply_integrity_monitor.sv */
// Supply integrity monitor: brown-out reset, watchdog reset pulse, supply warning flag and irq
//
// Functional notes
// - With enable set, every change of the warning flag after the reset delay requests an interrupt.
// - Pending warning request clears itself when the CPU enters its service routine.
// - Bit 5 is a read-only warning flag tracking the synchronised comparator one clock after the synchroniser output.
// - Interrupt reaches the CPU only with enable set and CPU mask cleared.
// - Warning interrupt wakes from WAIT, never from HALT.
// - In HALT the control/status register is frozen; only brown-out, watchdog and external resets still change it.
// - Warning flag and interrupt work only when the brown-out option is on.
// - Rising crossing inside the reset delay gives no interrupt.
// - Enabling while below threshold gives one interrupt, crossing gives another.
// - Enabling after the rising crossing gives exactly one interrupt.
// - Watchdog underflow drives the reset pin low for a minimum pulse.
// - Reset pin held low for the whole brown-out reset.
// - Static reset held while the low-voltage comparator reports low supply.
// - Brown-out reset is active only when selected by option.
// - Register resets to 000x 000x.
// - Bit 4 set by brown-out reset, cleared only by software writing zero.
// - Bit 0 set by watchdog reset, cleared by software zero, external reset or brown-out reset.
// - Cause flags read 00 external, 01 watchdog, 1x brown-out.
module supply_integrity_monitor #(
	parameter int DELAY_SHORT = supply_monitor_pkg::DELAY_SHORT_CYC,
	parameter int DELAY_LONG = supply_monitor_pkg::DELAY_LONG_CYC,
	parameter int WDG_PULSE = supply_monitor_pkg::WDG_PULSE_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic brownout_option_en,
	input wire logic reset_delay_long,
	input wire logic brownout_comp_low,
	input wire logic warn_comp_low,
	input wire logic wdg_underflow,
	input wire logic halt_mode,
	input wire logic wait_mode,
	input wire logic cpu_irq_mask,
	input wire logic irq_ack,
	input wire logic rst_pin_i,
	output logic rst_pin_o,
	output logic rst_pin_oe,
	output logic static_reset,
	output logic supply_irq,
	output logic wake_from_wait
);
	typedef struct packed {
		logic wr_pend;
		logic ie;
		logic flag;
		logic bo_cause;
		logic wdg_cause;
		logic pend;
		logic [supply_monitor_pkg::DLY_W-1:0] dly;
		logic [supply_monitor_pkg::WDG_W-1:0] wdg_cnt;
		logic [2:0] oe_hist;
		logic [31:0] rdata;
	} state_s;

	state_s st_q;
	state_s st_d;

	logic opt_s;
	logic bo_s;
	logic warn_s;
	logic rst_in_s;
	logic bo_rst;
	logic ext_rst;
	logic warn_now;
	logic armed;
	logic addr_hit;
	logic take;
	logic ie_rise;
	logic toggle;
	logic event_req;
	logic [7:0] csr_val;

	// Stretch length as stored in the counter
	localparam logic [supply_monitor_pkg::WDG_W-1:0] WDG_W_VAL = supply_monitor_pkg::WDG_W'(WDG_PULSE);

	function automatic logic [7:0] pack_csr(input state_s s);
		logic [7:0] v;
		v = supply_monitor_pkg::CSR_RESET;
		v[supply_monitor_pkg::IE_BIT] = s.ie;
		v[supply_monitor_pkg::FLAG_BIT] = s.flag;
		v[supply_monitor_pkg::BO_CAUSE_BIT] = s.bo_cause;
		v[supply_monitor_pkg::WDG_CAUSE_BIT] = s.wdg_cause;
		return v;
	endfunction

	// Option, comparators and pin are all outside this clock domain
	supply_sync #(.W(4), .RESET_VAL(4'h1)) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in({brownout_option_en, brownout_comp_low, warn_comp_low, rst_pin_i}),
		.sync_out({opt_s, bo_s, warn_s, rst_in_s})
	);

	assign bo_rst = opt_s & bo_s;
	assign static_reset = bo_rst;
	assign rst_pin_o = 1'b0;
	// Open drain: only ever pulls low
	assign rst_pin_oe = bo_rst | wdg_underflow | (st_q.wdg_cnt != '0);
	// Our own release takes a few cycles to show through the synchroniser
	assign ext_rst = !rst_in_s && !rst_pin_oe && (st_q.oe_hist == 3'h0);
	assign warn_now = opt_s & warn_s;
	assign armed = (st_q.dly == '0) && !bo_rst && !rst_pin_oe;
	assign addr_hit = haddr == supply_monitor_pkg::CSR_ADDR;
	assign take = hsel && hready && (htrans == supply_monitor_pkg::HTRANS_NONSEQ);
	assign csr_val = pack_csr(st_q);

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st_q.rdata;

	assign supply_irq = st_q.pend & st_q.ie & !cpu_irq_mask;
	assign wake_from_wait = supply_irq & wait_mode & !halt_mode;

	always_comb begin
		st_d = st_q;
		ie_rise = 1'b0;
		toggle = 1'b0;
		event_req = 1'b0;
		st_d.oe_hist = {st_q.oe_hist[1:0], rst_pin_oe};

		// Bus address phase; reads are answered with zero wait states
		st_d.wr_pend = take && hwrite && addr_hit && (hsize == supply_monitor_pkg::HSIZE_WORD);
		if (take && !hwrite) begin
			st_d.rdata = addr_hit ? {24'h00_0000, csr_val} : supply_monitor_pkg::RDATA_UNMAPPED;
		end

		// Watchdog pulse stretcher
		if (wdg_underflow) begin
			st_d.wdg_cnt = supply_monitor_pkg::WDG_W'(WDG_PULSE);
		end else if (st_q.wdg_cnt != '0) begin
			st_d.wdg_cnt = st_q.wdg_cnt - 1'b1;
		end

		// Reset delay phase: warning changes during it are absorbed silently
		if (bo_rst || ext_rst || rst_pin_oe) begin
			st_d.dly = reset_delay_long ? supply_monitor_pkg::DLY_W'(DELAY_LONG)
				: supply_monitor_pkg::DLY_W'(DELAY_SHORT);
		end else if (st_q.dly != '0) begin
			st_d.dly = st_q.dly - 1'b1;
		end

		if (!halt_mode) begin
			// Bit 7 and bits 3:1 are not stored
			if (st_q.wr_pend) begin
				st_d.ie = hwdata[supply_monitor_pkg::IE_BIT];
				if (!hwdata[supply_monitor_pkg::BO_CAUSE_BIT]) begin
					st_d.bo_cause = 1'b0;
				end
				if (!hwdata[supply_monitor_pkg::WDG_CAUSE_BIT]) begin
					st_d.wdg_cause = 1'b0;
				end
			end
			// Enable rising while the supply is low counts as an event of its own
			ie_rise = st_d.ie && !st_q.ie;
			toggle = warn_now != st_q.flag;
			st_d.flag = warn_now;
			// Nothing is requested until the reset delay has run out
			event_req = armed && ((toggle && st_d.ie) || (ie_rise && warn_now));
			if (irq_ack) begin
				st_d.pend = 1'b0;
			end
			// A new event in the ack cycle is kept
			if (event_req) begin
				st_d.pend = 1'b1;
			end
		end

		// Reset causes act even in HALT
		if (ext_rst) begin
			st_d.wdg_cause = 1'b0;
			st_d.ie = 1'b0;
			st_d.pend = 1'b0;
		end
		if (wdg_underflow) begin
			st_d.wdg_cause = 1'b1;
			st_d.ie = 1'b0;
			st_d.pend = 1'b0;
		end
		// Brown-out wins so the watchdog cause starts cleared
		if (bo_rst) begin
			st_d.bo_cause = 1'b1;
			st_d.wdg_cause = 1'b0;
			st_d.ie = 1'b0;
			st_d.pend = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	irq_gate_a: assert property (!st_q.ie || cpu_irq_mask |-> !supply_irq)
		else $error("irq leaked past enable or mask");

	irq_on_a: assert property (st_q.pend && st_q.ie && !cpu_irq_mask |-> supply_irq)
		else $error("pending irq not presented");

	flag_track_a: assert property (!halt_mode && !bo_rst |=> st_q.flag == ($past(opt_s) && $past(warn_s)))
		else $error("warning flag does not track comparator");

	// Read data shows the register as it stood at the address phase
	csr_read_a: assert property (take && !hwrite && addr_hit
		|=> hrdata[supply_monitor_pkg::IE_BIT] == $past(st_q.ie)
		&& hrdata[supply_monitor_pkg::FLAG_BIT] == $past(st_q.flag))
		else $error("read data does not match register");

	csr_reserved_a: assert property (hrdata[31:8] == 24'h00_0000 && !hrdata[7] && hrdata[3:1] == 3'h0)
		else $error("reserved read bits not zero");

	halt_freeze_a: assert property (halt_mode && !bo_rst && !wdg_underflow && !ext_rst
		|=> st_q.flag == $past(st_q.flag) && st_q.ie == $past(st_q.ie) && st_q.pend == $past(st_q.pend))
		else $error("register changed in halt");

	toggle_req_a: assert property (!halt_mode && armed && st_q.ie && !st_q.wr_pend
		&& (opt_s && warn_s) != st_q.flag && !wdg_underflow && !ext_rst |=> st_q.pend)
		else $error("flag toggle gave no request");

	ie_write_a: assert property (!halt_mode && st_q.wr_pend && !wdg_underflow && !ext_rst && !bo_rst
		|=> st_q.ie == $past(hwdata[supply_monitor_pkg::IE_BIT]))
		else $error("enable write lost");

	ie_off_quiet_a: assert property (!st_q.ie && !st_q.pend
		&& !(st_q.wr_pend && hwdata[supply_monitor_pkg::IE_BIT]) |=> !st_q.pend)
		else $error("request with enable clear");

	ie_rise_a: assert property (!halt_mode && st_q.wr_pend && hwdata[supply_monitor_pkg::IE_BIT]
		&& !st_q.ie && armed && warn_now && !wdg_underflow && !ext_rst |=> st_q.pend)
		else $error("enabling while low gave no request");

	ack_clear_a: assert property (irq_ack && !halt_mode && !armed |=> !st_q.pend)
		else $error("ack did not clear pending");

	halt_nowake_a: assert property (halt_mode |-> !wake_from_wait)
		else $error("woke from halt");

	wake_wait_a: assert property (supply_irq && wait_mode && !halt_mode |-> wake_from_wait)
		else $error("no wake from wait");

	wdg_pulse_a: assert property (wdg_underflow |=> rst_pin_oe [*8])
		else $error("watchdog reset pulse too short");

	wdg_len_a: assert property (wdg_underflow |=> st_q.wdg_cnt == WDG_W_VAL)
		else $error("watchdog stretch length wrong");

	wdg_count_a: assert property (st_q.wdg_cnt != '0 && !wdg_underflow
		|=> st_q.wdg_cnt == $past(st_q.wdg_cnt) - 1'b1)
		else $error("watchdog stretch does not count");

	oe_stretch_a: assert property (st_q.wdg_cnt != '0 |-> rst_pin_oe)
		else $error("pin released during watchdog pulse");

	bo_hold_a: assert property (opt_s && bo_s |-> rst_pin_oe && !rst_pin_o && static_reset)
		else $error("pin released during brown-out");

	static_pin_a: assert property (static_reset |-> rst_pin_oe)
		else $error("static reset without pin drive");

	opt_static_a: assert property (!opt_s |-> !static_reset)
		else $error("brown-out reset with option off");

	// Halt in the cycle before would leave the flag frozen, so it is excluded there
	opt_off_a: assert property (!opt_s && !halt_mode |=> !st_q.flag)
		else $error("warning active with option off");

	delay_load_a: assert property (bo_rst || rst_pin_oe |=> st_q.dly != '0)
		else $error("reset delay not loaded");

	delay_count_a: assert property (st_q.dly != '0 && !bo_rst && !ext_rst && !rst_pin_oe
		|=> st_q.dly == $past(st_q.dly) - 1'b1)
		else $error("reset delay does not count");

	delay_quiet_a: assert property (st_q.dly != '0 && !irq_ack && !halt_mode && !st_q.pend
		|=> !st_q.pend)
		else $error("request during reset delay");

	cause_flags_a: assert property (bo_rst |=> st_q.bo_cause && !st_q.wdg_cause)
		else $error("brown-out cause flags wrong");

	// Only a software zero may clear the brown-out cause
	bo_keep_a: assert property (st_q.bo_cause
		&& !(st_q.wr_pend && !halt_mode && !hwdata[supply_monitor_pkg::BO_CAUSE_BIT])
		|=> st_q.bo_cause)
		else $error("brown-out cause lost");

	wdg_cause_a: assert property (wdg_underflow && !bo_rst |=> st_q.wdg_cause)
		else $error("watchdog cause not set");

	wdg_clears_a: assert property (wdg_underflow |=> !st_q.ie && !st_q.pend)
		else $error("watchdog reset left enable or pending");

	ext_cause_a: assert property (ext_rst && !wdg_underflow && !bo_rst |=> !st_q.wdg_cause)
		else $error("external reset kept watchdog cause");
endmodule

/* File: hdl/supply_monitor_pkg.sv */
// Constants shared by the supply integrity monitor
package supply_monitor_pkg;
	// Register map: one control/status word
	localparam logic [31:0] CSR_ADDR = 32'h0000_0000;
	localparam logic [7:0] CSR_RESET = 8'h00;
	localparam int IE_BIT = 6;
	localparam int FLAG_BIT = 5;
	localparam int BO_CAUSE_BIT = 4;
	localparam int WDG_CAUSE_BIT = 0;

	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int DELAY_SHORT_CYC = 256;
	localparam int DELAY_LONG_CYC = 4096;
	localparam int WDG_PULSE_MIN_NS = 30000;
	localparam int WDG_PULSE_CYC = (WDG_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DLY_W = 13;
	localparam int WDG_W = 16;
endpackage

/* File: hdl/supply_sync.sv */
// Two flip-flop synchroniser for asynchronous levels
module supply_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// First stage feeds only the second stage
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule

/* File: test/supply_cpu_model.sv */
// CPU side model: takes the warning request and enters service after a latency
module supply_cpu_model #(
	parameter int LAT = 2
) (
	input wire logic hclk,
	input wire logic supply_irq,
	input wire logic ack_en,
	output logic irq_ack,
	output logic [7:0] n_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	initial begin
		irq_ack = 1'h0;
		n_irq = 8'h00;
	end
	// Latency lets the request stand a while, as a busy CPU would
	always @(posedge hclk) begin
		irq_ack <= 1'h0;
		if (supply_irq && ack_en && !irq_ack) begin
			cnt <= cnt + 1;
			if (cnt == LAT) begin
				irq_ack <= 1'h1;
				n_irq <= n_irq + 8'h01;
				cnt <= 0;
			end
		end else begin
			cnt <= 0;
		end
	end
endmodule

/* File: test/supply_integrity_monitor_test.sv */
// Register bus bench for the supply integrity monitor
module supply_integrity_monitor_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, hready;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic opt = 1'h1, dlong = 1'h1, bo = 1'h0, warn = 1'h0, wdg = 1'h0, halt = 1'h0;
	logic waitm = 1'h0, mask = 1'h0, ack_en = 1'h1, pin_i, pin_o, pin_oe;
	logic sres, irq, wake, hresp, ack;
	logic [7:0] n_irq;
	int n_mismatch = 0, checked = 0, n = 0;
	always #25 hclk = ~hclk;
	// Open-drain pin with pull-up
	assign pin_i = pin_oe ? pin_o : 1'h1;
	supply_integrity_monitor #(.DELAY_SHORT(4), .DELAY_LONG(16), .WDG_PULSE(8))
	i_supply_integrity_monitor (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
		.brownout_option_en(opt), .reset_delay_long(dlong), .brownout_comp_low(bo),
		.warn_comp_low(warn), .wdg_underflow(wdg), .halt_mode(halt), .wait_mode(waitm),
		.cpu_irq_mask(mask), .irq_ack(ack), .rst_pin_i(pin_i), .rst_pin_o(pin_o),
		.rst_pin_oe(pin_oe), .static_reset(sres), .supply_irq(irq), .wake_from_wait(wake));
	supply_cpu_model i_supply_cpu_model (.hclk(hclk), .supply_irq(irq), .ack_en(ack_en),
		.irq_ack(ack), .n_irq(n_irq));
	task automatic chk(string w, logic [31:0] s, logic [31:0] e);
		checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", w, e, s);
		end
	endtask
	task automatic bus(logic wr, logic [31:0] a, logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= supply_monitor_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		haddr <= a;
		do @(posedge hclk); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'h1);
		rd = hrdata;
	endtask
	task automatic rdchk(string w, logic [31:0] e);
		bus(1'h0, supply_monitor_pkg::CSR_ADDR, 32'h0);
		chk(w, rd, e);
	endtask
	// Combinational outputs are sampled mid-cycle so no edge race decides them
	task automatic sig(string w, ref logic s, input logic [31:0] e);
		@(negedge hclk);
		chk(w, {31'h0, s}, e);
		@(posedge hclk);
	endtask
	task automatic cnt(int e);
		@(negedge hclk);
		chk("irq count", {24'h0, n_irq}, e);
		@(posedge hclk);
	endtask
	task automatic cyc(int k);
		repeat (k) @(posedge hclk);
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		cyc(4);
		hresetn <= 1'h1;
		cyc(20);
		rdchk("reset value", 32'h0);
		bus(1'h1, 32'h4, 32'h7f);
		rdchk("unmapped write", 32'h0);
		bus(1'h1, supply_monitor_pkg::CSR_ADDR, 32'h40);
		warn <= 1'h1;
		cyc(4);
		rdchk("flag high", 32'h60);
		cnt(1);
		warn <= 1'h0;
		cyc(10);
		cnt(2);
		$display("toggle test done");
		ack_en <= 1'h0;
		mask <= 1'h1;
		warn <= 1'h1;
		cyc(5);
		sig("masked", irq, 0);
		mask <= 1'h0;
		waitm <= 1'h1;
		sig("wake", wake, 1);
		halt <= 1'h1;
		warn <= 1'h0;
		sig("halt wake", wake, 0);
		cyc(5);
		rdchk("frozen", 32'h60);
		warn <= 1'h1;
		cyc(5);
		halt <= 1'h0;
		waitm <= 1'h0;
		ack_en <= 1'h1;
		cyc(10);
		cnt(3);
		sig("irq cleared", irq, 0);
		warn <= 1'h0;
		cyc(10);
		opt <= 1'h0;
		bo <= 1'h1;
		warn <= 1'h1;
		cyc(5);
		sig("option off", sres, 0);
		rdchk("flag off", 32'h40);
		cnt(4);
		$display("mode test done");
		warn <= 1'h0;
		opt <= 1'h1;
		cyc(4);
		sig("static reset", sres, 1);
		sig("pin held", pin_oe, 1);
		bo <= 1'h0;
		cyc(4);
		rdchk("brown-out cause", 32'h10);
		bus(1'h1, supply_monitor_pkg::CSR_ADDR, 32'h50);
		warn <= 1'h1;
		cyc(30);
		cnt(4);
		bus(1'h1, supply_monitor_pkg::CSR_ADDR, 32'h10);
		bus(1'h1, supply_monitor_pkg::CSR_ADDR, 32'h50);
		cyc(8);
		cnt(5);
		warn <= 1'h0;
		cyc(10);
		cnt(6);
		$display("brown-out test done");
		wdg <= 1'h1;
		@(posedge hclk);
		wdg <= 1'h0;
		repeat (100) begin
			@(negedge hclk);
			n += int'(pin_oe === 1'h1);
		end
		chk("pulse length", {31'h0, n >= 8 && n < 100}, 1);
		rdchk("watchdog cause", 32'h11);
		bus(1'h1, supply_monitor_pkg::CSR_ADDR, 32'h0);
		rdchk("causes cleared", 32'h0);
		$display("watchdog test done");
		finish_test();
	end
	initial begin
		cyc(5000);
		n_mismatch++;
		finish_test();
	end
endmodule
